/* File: sqsr_consts.svh */
// Purpose: offsets, field masks, reset values and crc constants of the sequencer status bank
// Assumes: byte-wide registers behind a two-wire serial slave
// Notes:   definitions only
`ifndef SQSR_CONSTS_SVH
`define SQSR_CONSTS_SVH

// register offsets
`define SQSR_A_MODEL      8'h00
`define SQSR_A_REV        8'h01
`define SQSR_A_SRC1       8'h10
`define SQSR_A_SRC2       8'h11
`define SQSR_A_MAKER      8'h12
`define SQSR_A_CTLSTAT    8'h13
`define SQSR_A_DOWN_HI    8'h14
`define SQSR_A_DOWN_LO    8'h15
`define SQSR_A_UP_HI      8'h16
`define SQSR_A_UP_LO      8'h17
`define SQSR_A_WDT        8'h18
`define SQSR_A_TEST       8'h19
`define SQSR_A_LASTRST    8'h1a
`define SQSR_A_ALT_EN     8'h20
`define SQSR_A_ALT_DIR    8'h21
`define SQSR_A_DRV_HI     8'h22
`define SQSR_A_DRV_LO     8'h23
`define SQSR_A_CLKCFG     8'h24
`define SQSR_A_GPOUT      8'h25
`define SQSR_A_DEBOUNCE   8'h26
`define SQSR_A_LPRESS     8'h27
`define SQSR_A_CTL1       8'h28

// reset values
`define SQSR_RST_SRC      8'h00
`define SQSR_RST_MAKER    8'h00
`define SQSR_RST_CTLSTAT  8'h00

// implemented bits (reserved bits read zero)
`define SQSR_M_NIBBLE     8'h0f
`define SQSR_M_CTLSTAT    8'h7f
`define SQSR_M_WDT        8'h0b
`define SQSR_M_TEST       8'h6f
`define SQSR_M_CLKCFG     8'hd0
`define SQSR_M_DEBOUNCE   8'hfe
`define SQSR_M_SRC2       8'hbf

// packet error check byte
`define SQSR_CRC_POLY     8'h07
`define SQSR_CRC_INIT     8'h00

`endif

/* File: sqsr_pkg.sv */
// Purpose: types and crc arithmetic of the sequencer status bank
// Assumes: sqsr_consts.svh carries the numbers
// Notes:   crc step shared by the crc module and the checks
`include "sqsr_consts.svh"

package sqsr_pkg;

  typedef logic [7:0] sqsr_byte_t;

  // serial slave states, one-hot
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_RX    = 6'h02,
    S_AWAIT = 6'h04,
    S_ACK   = 6'h08,
    S_TX    = 6'h10,
    S_MACK  = 6'h20
  } sqsr_state_e;

  // crc-8 x^8+x^2+x+1, msb first, one byte folded in
  function automatic sqsr_byte_t sqsr_crc_byte(input sqsr_byte_t c, input sqsr_byte_t d);
    sqsr_byte_t r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
    begin
      r = r[7] ? ({r[6:0], 1'b0} ^ `SQSR_CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

endpackage

/* File: sqsr_crc8.sv */
// Purpose: running packet error check over the bytes of one transfer
// Assumes: clr and add are single-cycle strobes on mclk
// Notes:   clr wins over add
`timescale 1ns/1ps
`include "sqsr_consts.svh"

module sqsr_crc8 (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              clr,
  input  wire logic              add,
  input  wire sqsr_pkg::sqsr_byte_t din,
  output sqsr_pkg::sqsr_byte_t   crc
);

  sqsr_pkg::sqsr_byte_t next_crc;

  // restart from the initial value or fold in one byte
  always_comb
  begin
    next_crc = crc;
    if (clr)
      next_crc = `SQSR_CRC_INIT;
    else if (add)
      next_crc = sqsr_pkg::sqsr_crc_byte(crc, din);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      crc <= `SQSR_CRC_INIT;
    else
      crc <= next_crc;
  end

  crc_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clr |=> crc == `SQSR_CRC_INIT)
    else $error("crc not restarted");

endmodule // sqsr_crc8

/* File: sqsr_regs.sv */
// Purpose: serial slave with register bank 0x00-0x28 and optional crc byte on reads
// Assumes: scl and sda_in are raw pins, arst_n is asynchronous; all other inputs are on mclk
// Notes:   sda is open drain, only ever pulled low while sda_oe is high
//
// Overview of operation
// - crc checking off: a read answers register data only, no check byte.
// - crc checking on: each data byte the host acks is followed by its check byte.
// - fault flag register at 0x12 holds internal faults, cleared by writing ones.
// - read-only status at 0x13, reset 0x00: battery, pins, sleep, shutdown, state.
// - check byte is crc-8 x^8+x^2+x+1 starting from zero.
// - crc covers address, command and data bytes, never acks or conditions.
`timescale 1ns/1ps
`include "sqsr_consts.svh"

module sqsr_regs #(
  parameter logic [6:0] DEV_ADDR    = 7'h30,
  parameter logic [7:0] MODEL_ID    = 8'h11, // arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h01, // arbitrary value
  parameter logic [7:0] NVM_ALT_EN  = 8'h00,
  parameter logic [7:0] NVM_ALT_DIR = 8'h00,
  parameter logic [7:0] NVM_DRV_HI  = 8'h00,
  parameter logic [7:0] NVM_DRV_LO  = 8'h00,
  parameter logic [7:0] NVM_CLKCFG  = 8'h00,
  parameter logic [7:0] NVM_GPOUT   = 8'h00,
  parameter logic [7:0] NVM_DEB     = 8'h00,
  parameter logic [7:0] NVM_LPRESS  = 8'h00,
  parameter logic [7:0] NVM_CTL1    = 8'h00
) (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       crc_check_on,
  input  wire logic [7:0] evt_src1,
  input  wire logic [7:0] evt_src2,
  input  wire logic [7:0] evt_maker,
  input  wire logic       on_backup_battery,
  input  wire logic       irq_pin_level,
  input  wire logic       reset_pin_level,
  input  wire logic       sleep_active,
  input  wire logic       shutdown_active,
  input  wire logic [1:0] sequencer_state,
  input  wire logic [7:0] rail_down_hi,
  input  wire logic [7:0] rail_down_lo,
  input  wire logic [7:0] rail_up_hi,
  input  wire logic [7:0] rail_up_lo,
  input  wire logic [7:0] wdt_state,
  input  wire logic [7:0] test_state,
  input  wire logic [7:0] reset_cause,
  output logic [7:0]      general_outputs,
  output logic [7:0]      input_debounce,
  output logic [7:0]      long_press_threshold,
  output logic [7:0]      control_first
);

  logic                   rst_q1;
  logic                   rst_n;
  logic                   scl_s1;
  logic                   scl_s2;
  logic                   scl_d;
  logic                   sda_s1;
  logic                   sda_s2;
  logic                   sda_d;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_c;
  logic                   stop_c;
  sqsr_pkg::sqsr_state_e  st;
  sqsr_pkg::sqsr_state_e  next_st;
  logic [2:0]             bcnt;
  logic [2:0]             next_bcnt;
  logic [7:0]             sh;
  logic [7:0]             next_sh;
  logic [7:0]             tx_sh;
  logic [7:0]             next_tx_sh;
  logic [7:0]             ptr;
  logic [7:0]             next_ptr;
  logic [1:0]             idx;
  logic [1:0]             next_idx;
  logic                   rw;
  logic                   next_rw;
  logic                   nack;
  logic                   next_nack;
  logic                   tx_pec;
  logic                   next_tx_pec;
  logic                   in_xfer;
  logic                   next_in_xfer;
  logic                   wr_en;
  logic                   crc_clr;
  logic                   crc_add;
  logic [7:0]             crc_din;
  logic [7:0]             crc;
  logic [7:0]             rx_byte;
  logic [7:0]             rd_val;
  logic [7:0]             interrupt_source_first;
  logic [7:0]             interrupt_source_second;
  logic [7:0]             maker_fault_flags;
  logic [7:0]             control_status;
  logic [7:0]             next_src1;
  logic [7:0]             next_src2;
  logic [7:0]             next_maker;
  logic [7:0]             next_ctlstat;
  logic [7:0]             next_gpout;
  logic [7:0]             next_deb;
  logic [7:0]             next_lpress;
  logic [7:0]             next_ctl1;

  // reset release through two flip-flops
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // pin synchronisers, idle level high
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end
    else
    begin
      scl_s1 <= scl;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  // line events seen on the synchronised copies
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_c  = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_c   = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign rx_byte  = {sh[6:0], sda_s2};

  // open-drain drive: ack and zero data bits pull low
  assign sda_out = 1'b0;
  assign sda_oe  = (st == sqsr_pkg::S_ACK) | ((st == sqsr_pkg::S_TX) & ~tx_sh[7]);

  // read data of the register under the pointer
  always_comb
  begin
    unique case (ptr)
      `SQSR_A_MODEL:    rd_val = MODEL_ID;
      `SQSR_A_REV:      rd_val = REVISION_ID;
      `SQSR_A_SRC1:     rd_val = interrupt_source_first;
      `SQSR_A_SRC2:     rd_val = interrupt_source_second;
      `SQSR_A_MAKER:    rd_val = maker_fault_flags;
      `SQSR_A_CTLSTAT:  rd_val = control_status;
      `SQSR_A_DOWN_HI:  rd_val = rail_down_hi & `SQSR_M_NIBBLE;
      `SQSR_A_DOWN_LO:  rd_val = rail_down_lo;
      `SQSR_A_UP_HI:    rd_val = rail_up_hi & `SQSR_M_NIBBLE;
      `SQSR_A_UP_LO:    rd_val = rail_up_lo;
      `SQSR_A_WDT:      rd_val = wdt_state & `SQSR_M_WDT;
      `SQSR_A_TEST:     rd_val = test_state & `SQSR_M_TEST;
      `SQSR_A_LASTRST:  rd_val = reset_cause;
      `SQSR_A_ALT_EN:   rd_val = NVM_ALT_EN & `SQSR_M_NIBBLE;
      `SQSR_A_ALT_DIR:  rd_val = NVM_ALT_DIR & `SQSR_M_NIBBLE;
      `SQSR_A_DRV_HI:   rd_val = NVM_DRV_HI & `SQSR_M_NIBBLE;
      `SQSR_A_DRV_LO:   rd_val = NVM_DRV_LO;
      `SQSR_A_CLKCFG:   rd_val = NVM_CLKCFG & `SQSR_M_CLKCFG;
      `SQSR_A_GPOUT:    rd_val = general_outputs;
      `SQSR_A_DEBOUNCE: rd_val = input_debounce;
      `SQSR_A_LPRESS:   rd_val = long_press_threshold;
      `SQSR_A_CTL1:     rd_val = control_first;
      default:          rd_val = 8'h00; // unmapped and reserved read zero
    endcase
  end

  // serial slave: byte framing, acks, transmit and crc feed
  always_comb
  begin
    next_st      = st;
    next_bcnt    = bcnt;
    next_sh      = sh;
    next_tx_sh   = tx_sh;
    next_ptr     = ptr;
    next_idx     = idx;
    next_rw      = rw;
    next_nack    = nack;
    next_tx_pec  = tx_pec;
    next_in_xfer = in_xfer;
    wr_en        = 1'b0;
    crc_clr      = 1'b0;
    crc_add      = 1'b0;
    crc_din      = rx_byte;
    if (stop_c)
    begin
      next_st      = sqsr_pkg::S_IDLE;
      next_in_xfer = 1'b0;
    end
    else if (start_c)
    begin
      next_st      = sqsr_pkg::S_RX;
      next_bcnt    = 3'h0;
      next_idx     = 2'h0;
      next_in_xfer = 1'b1;
      crc_clr      = ~in_xfer; // repeated start keeps the running crc
    end
    else
    begin
      unique case (st)
        sqsr_pkg::S_IDLE: ;
        sqsr_pkg::S_RX:
          if (scl_rise)
          begin
            next_sh   = rx_byte;
            next_bcnt = bcnt + 3'h1;
            if (bcnt == 3'h7)
            begin
              crc_add = 1'b1; // every received byte counts
              next_st = sqsr_pkg::S_AWAIT;
              if (idx != 2'h2)
                next_idx = idx + 2'h1;
              if (idx == 2'h0)
              begin
                next_rw = rx_byte[0];
                if (rx_byte[7:1] != DEV_ADDR)
                  next_st = sqsr_pkg::S_IDLE;
              end
              else if (idx == 2'h1)
                next_ptr = rx_byte;
              else
              begin
                wr_en    = 1'b1;
                next_ptr = ptr + 8'h01;
              end
            end
          end
        sqsr_pkg::S_AWAIT:
          if (scl_fall)
            next_st = sqsr_pkg::S_ACK;
        sqsr_pkg::S_ACK:
          if (scl_fall)
          begin
            next_bcnt = 3'h0;
            next_st   = sqsr_pkg::S_RX;
            if (rw)
            begin
              next_st     = sqsr_pkg::S_TX;
              next_tx_sh  = rd_val;
              next_tx_pec = 1'b0;
              next_ptr    = ptr + 8'h01;
              crc_add     = 1'b1; // sent data byte counts
              crc_din     = rd_val;
            end
          end
        sqsr_pkg::S_TX:
          if (scl_fall)
          begin
            if (bcnt == 3'h7)
              next_st = sqsr_pkg::S_MACK;
            else
            begin
              next_tx_sh = {tx_sh[6:0], 1'b0};
              next_bcnt  = bcnt + 3'h1;
            end
          end
        sqsr_pkg::S_MACK:
          if (scl_rise)
            next_nack = sda_s2;
          else if (scl_fall)
          begin
            next_bcnt = 3'h0;
            next_st   = nack ? sqsr_pkg::S_IDLE : sqsr_pkg::S_TX;
            if (!nack && crc_check_on && !tx_pec)
            begin
              next_tx_sh  = crc; // check byte follows the data
              next_tx_pec = 1'b1;
            end
            else if (!nack)
            begin
              next_tx_sh  = rd_val; // no check byte when off
              next_tx_pec = 1'b0;
              next_ptr    = ptr + 8'h01;
              crc_add     = 1'b1;
              crc_din     = rd_val;
            end
          end
        default: next_st = sqsr_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st      <= sqsr_pkg::S_IDLE;
      bcnt    <= 3'h0;
      sh      <= 8'h00;
      tx_sh   <= 8'hff;
      ptr     <= 8'h00;
      idx     <= 2'h0;
      rw      <= 1'b0;
      nack    <= 1'b0;
      tx_pec  <= 1'b0;
      in_xfer <= 1'b0;
    end
    else
    begin
      st      <= next_st;
      bcnt    <= next_bcnt;
      sh      <= next_sh;
      tx_sh   <= next_tx_sh;
      ptr     <= next_ptr;
      idx     <= next_idx;
      rw      <= next_rw;
      nack    <= next_nack;
      tx_pec  <= next_tx_pec;
      in_xfer <= next_in_xfer;
    end
  end

  // running check value over the transfer
  sqsr_crc8 u_crc (
    .mclk (mclk),
    .rst_n(rst_n),
    .clr  (crc_clr),
    .add  (crc_add),
    .din  (crc_din),
    .crc  (crc)
  );

  // register bank: flags set by events, cleared by written ones
  always_comb
  begin
    next_src1    = interrupt_source_first | evt_src1;
    next_src2    = (interrupt_source_second | evt_src2) & `SQSR_M_SRC2;
    next_maker   = maker_fault_flags | evt_maker;
    next_ctlstat = {1'b0, on_backup_battery, irq_pin_level, reset_pin_level,
                    sleep_active, shutdown_active, sequencer_state};
    next_gpout   = general_outputs;
    next_deb     = input_debounce;
    next_lpress  = long_press_threshold;
    next_ctl1    = control_first;
    if (wr_en)
    begin
      unique case (ptr)
        `SQSR_A_SRC1:     next_src1   = (interrupt_source_first & ~rx_byte) | evt_src1;
        `SQSR_A_SRC2:     next_src2   = ((interrupt_source_second & ~rx_byte) | evt_src2) & `SQSR_M_SRC2;
        `SQSR_A_MAKER:    next_maker  = (maker_fault_flags & ~rx_byte) | evt_maker;
        `SQSR_A_GPOUT:    next_gpout  = rx_byte;
        `SQSR_A_DEBOUNCE: next_deb    = rx_byte & `SQSR_M_DEBOUNCE;
        `SQSR_A_LPRESS:   next_lpress = rx_byte;
        `SQSR_A_CTL1:     next_ctl1   = rx_byte & `SQSR_M_NIBBLE;
        default: ; // read-only and unmapped ignore writes
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      interrupt_source_first             <= `SQSR_RST_SRC;
      interrupt_source_second             <= `SQSR_RST_SRC;
      maker_fault_flags    <= `SQSR_RST_MAKER;
      control_status       <= `SQSR_RST_CTLSTAT;
      general_outputs      <= NVM_GPOUT;
      input_debounce       <= NVM_DEB & `SQSR_M_DEBOUNCE;
      long_press_threshold <= NVM_LPRESS;
      control_first        <= NVM_CTL1 & `SQSR_M_NIBBLE;
    end
    else
    begin
      interrupt_source_first             <= next_src1;
      interrupt_source_second             <= next_src2;
      maker_fault_flags    <= next_maker;
      control_status       <= next_ctlstat;
      general_outputs      <= next_gpout;
      input_debounce       <= next_deb;
      long_press_threshold <= next_lpress;
      control_first        <= next_ctl1;
    end
  end

  // checks on the serial side and the bank
  pec_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(tx_pec) |-> $past(crc_check_on))
    else $error("check byte sent while checking off");

  pec_follows_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (st == sqsr_pkg::S_MACK && scl_fall && !nack && !tx_pec && crc_check_on)
    |=> tx_pec && tx_sh == $past(crc) && st == sqsr_pkg::S_TX)
    else $error("check byte did not follow data");

  maker_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_en && ptr == `SQSR_A_MAKER && evt_maker == 8'h00)
    |=> (maker_fault_flags & $past(rx_byte)) == 8'h00)
    else $error("fault flags not cleared by ones");

  ctl_status_a: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> control_status == {1'b0, $past(on_backup_battery), $past(irq_pin_level),
      $past(reset_pin_level), $past(sleep_active), $past(shutdown_active),
      $past(sequencer_state)})
    else $error("control status mismatch");

  set_wins_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (evt_src1 != 8'h00) |=> (interrupt_source_first & $past(evt_src1)) == $past(evt_src1))
    else $error("source event lost");

  zero_keeps_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_en && ptr == `SQSR_A_SRC1) |=> (interrupt_source_first & ~$past(rx_byte)) ==
      $past((interrupt_source_first | evt_src1) & ~rx_byte))
    else $error("zero write changed a flag");

  crc_value_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (crc_add && !crc_clr) |=> crc == sqsr_pkg::sqsr_crc_byte($past(crc), $past(crc_din)))
    else $error("crc step wrong");

  crc_cover_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (st == sqsr_pkg::S_RX && scl_rise && bcnt == 3'h7 && !start_c && !stop_c) |-> crc_add)
    else $error("received byte missed by crc");

  // a sent byte is folded in whole at its first bit, never an ack slot
  tx_fold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (crc_add && st != sqsr_pkg::S_RX) |=> st == sqsr_pkg::S_TX && tx_sh == $past(crc_din))
    else $error("crc fold differs from sent byte");

  read_pec_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(tx_pec));
  write_c: cover property (@(posedge mclk) disable iff (!rst_n) wr_en);
  clear_c: cover property (@(posedge mclk) disable iff (!rst_n)
    wr_en && ptr == `SQSR_A_SRC1 && (interrupt_source_first & rx_byte) != 8'h00);
  nack_c: cover property (@(posedge mclk) disable iff (!rst_n)
    st == sqsr_pkg::S_MACK && scl_fall && nack);

endmodule // sqsr_regs

/* File: sqsr_host.sv */
// Purpose: serial bus host that clocks scl and reads or writes bytes
// Assumes: sda is a pulled-up wire, this side only ever pulls it low
// Notes:   scl stands high between frames; q sets a quarter bit period
`timescale 1ns/1ps

module sqsr_host (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  realtime q = 31.25;

  // idle bus: both lines released
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // one bit: data set while scl low, sampled in the middle of scl high
  task automatic bitx(input logic b, output logic r);
    scl = 1'b0;
    #q sda_pull = !b;
    #q scl = 1'b1;
    #q r = sda;
    #q;
  endtask

  // byte msb first, then the ack slot, which is never folded into the crc
  task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] r,
                      output logic a);
    for (int i = 7; i >= 0; i--)
    begin
      bitx(d[i], r[i]);
    end
    bitx(ab, a);
  endtask

  task automatic start();
    #q sda_pull = 1'b1;
    #q;
  endtask

  task automatic rstart();
    scl = 1'b0;
    #q sda_pull = 1'b0;
    #q scl = 1'b1;
    #q sda_pull = 1'b1;
    #q;
  endtask

  task automatic stop();
    scl = 1'b0;
    #q sda_pull = 1'b1;
    #q scl = 1'b1;
    #q sda_pull = 1'b0;
    #q;
  endtask
endmodule // sqsr_host

/* File: testbench.sv */
// Purpose: self-checking bench of the sequencer status bank over the serial bus
// Assumes: host model on scl and sda, other inputs driven on the falling mclk edge
// Notes:   expected check bytes are worked out here from the polynomial
`timescale 1ns/1ps
`include "sqsr_consts.svh"

module testbench;
  localparam logic [6:0] DEV = 7'h30;
  logic       mclk = 1'b0;
  logic       arst_n = 1'b0;
  logic       crc_on = 1'b0;
  logic [6:0] st = 7'h00;
  logic [7:0] live = 8'h00;
  logic [7:0] ev [3] = '{8'h00, 8'h00, 8'h00};
  logic       sda_oe;
  logic       scl;
  logic       pull;
  logic [7:0] gpo;
  logic [7:0] deb;
  logic [7:0] lpt;
  logic [7:0] ctl;
  wire        sda = !(sda_oe || pull);
  int         n_mismatch = 0;
  int         n_tests = 0;

  sqsr_regs #(.DEV_ADDR(DEV), .NVM_LPRESS(8'h3c)) i_dut (
    .mclk(mclk), .arst_n(arst_n), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .crc_check_on(crc_on), .evt_src1(ev[0]), .evt_src2(ev[1]), .evt_maker(ev[2]),
    .on_backup_battery(st[6]), .irq_pin_level(st[5]), .reset_pin_level(st[4]),
    .sleep_active(st[3]), .shutdown_active(st[2]), .sequencer_state(st[1:0]),
    .rail_down_hi(live), .rail_down_lo(live), .rail_up_hi(live), .rail_up_lo(live),
    .wdt_state(live), .test_state(live), .reset_cause(live), .general_outputs(gpo),
    .input_debounce(deb), .long_press_threshold(lpt), .control_first(ctl));

  sqsr_host i_host (.scl(scl), .sda_pull(pull), .sda(sda));

  always #5 mclk = ~mclk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // crc-8 x^8+x^2+x+1, msb first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
    begin
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  task automatic put(input logic [7:0] d, input logic exp_a);
    logic [7:0] r;
    logic       a;
    i_host.xfer(d, 1'b1, r, a);
    chk({7'h00, a}, {7'h00, exp_a});
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_host.start();
    put({DEV, 1'b0}, 1'b0);
    put(p, 1'b0);
    put(d, 1'b0);
    i_host.stop();
  endtask

  // pointer write, repeated start, nb bytes acked except the last
  task automatic rd(input logic [7:0] p, input int nb, output logic [7:0] b [4]);
    logic a;
    i_host.start();
    put({DEV, 1'b0}, 1'b0);
    put(p, 1'b0);
    i_host.rstart();
    put({DEV, 1'b1}, 1'b0);
    for (int i = 0; i < nb; i++)
    begin
      i_host.xfer(8'hff, i == nb - 1, b[i], a);
    end
    i_host.stop();
  endtask

  task automatic rd1(input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] b [4];
    rd(p, 1, b);
    chk(b[0], exp);
  endtask

  task automatic t_reset();
    logic [7:0] b [4];
    rd(`SQSR_A_SRC1, 4, b);
    for (int i = 0; i < 4; i++)
    begin
      chk(b[i], 8'h00);
    end
    rd1(`SQSR_A_LPRESS, 8'h3c);
    chk(lpt, 8'h3c);
  endtask

  task automatic t_status();
    @(negedge mclk) st = 7'h55;
    rd1(`SQSR_A_CTLSTAT, 8'h55);
    wr(`SQSR_A_CTLSTAT, 8'hff);
    rd1(`SQSR_A_CTLSTAT, 8'h55);
    @(negedge mclk) st = 7'h2a;
    rd1(`SQSR_A_CTLSTAT, 8'h2a);
  endtask

  // set by event, one clears, zero keeps, a held event beats the clear
  task automatic t_flags();
    logic [7:0] a;
    logic [7:0] m;
    for (int j = 0; j < 3; j++)
    begin
      a = `SQSR_A_SRC1 + 8'(j);
      m = (j == 1) ? `SQSR_M_SRC2 : 8'hff;
      @(negedge mclk) ev[j] = 8'hff;
      @(negedge mclk) ev[j] = 8'h00;
      rd1(a, m);
      wr(a, 8'h0f);
      rd1(a, m & 8'hf0);
      @(negedge mclk) ev[j] = 8'h10;
      wr(a, 8'hff);
      rd1(a, 8'h10);
      @(negedge mclk) ev[j] = 8'h00;
      wr(a, 8'hff);
      rd1(a, 8'h00);
    end
  endtask

  task automatic t_live();
    logic [7:0] m [7] = '{`SQSR_M_NIBBLE, 8'hff, `SQSR_M_NIBBLE, 8'hff, `SQSR_M_WDT,
                          `SQSR_M_TEST, 8'hff};
    for (int k = 0; k < 2; k++)
    begin
      @(negedge mclk) live = k ? 8'h5a : 8'hff;
      for (int i = 0; i < 7; i++)
      begin
        rd1(`SQSR_A_DOWN_HI + 8'(i), live & m[i]);
      end
    end
  endtask

  // check byte after each data byte, then the next register
  task automatic t_crc();
    logic [7:0] b [4];
    logic [7:0] c;
    logic [7:0] p [3] = '{`SQSR_A_CTLSTAT, `SQSR_A_LPRESS, `SQSR_A_SRC1};
    logic [7:0] e [3] = '{8'h2a, 8'h3c, 8'h00};
    logic [7:0] n [3] = '{8'h0a, 8'h00, 8'h00};
    rd(`SQSR_A_CTLSTAT, 2, b);
    chk(b[1], 8'h0a);
    @(negedge mclk) crc_on = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      rd(p[i], 3, b);
      c = crc8(crc8(crc8(crc8(8'h00, {DEV, 1'b0}), p[i]), {DEV, 1'b1}), e[i]);
      chk(b[0], e[i]);
      chk(b[1], c);
      chk(b[2], n[i]);
    end
    @(negedge mclk) crc_on = 1'b0;
    rd1(`SQSR_A_CTLSTAT, 8'h2a);
  endtask

  task automatic t_rw();
    wr(`SQSR_A_GPOUT, 8'ha5);
    wr(`SQSR_A_DEBOUNCE, 8'hff);
    wr(`SQSR_A_CTL1, 8'hff);
    rd1(`SQSR_A_GPOUT, 8'ha5);
    rd1(`SQSR_A_DEBOUNCE, `SQSR_M_DEBOUNCE);
    rd1(`SQSR_A_CTL1, 8'h0f);
    chk(gpo, 8'ha5);
    chk(deb, 8'hfe);
    chk(ctl, 8'h0f);
    rd1(8'h30, 8'h00);
    i_host.start();
    put({7'h31, 1'b0}, 1'b1);
    i_host.stop();
  endtask

  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(negedge mclk);
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_reset();
    t_status();
    t_flags();
    t_live();
    t_crc();
    t_rw();
    results();
  end

  // hang guard
  initial
  begin
    #800us;
    n_mismatch++;
    results();
  end
endmodule // testbench
